// ### pkg/capcmp_regs.vh
// Purpose: register map and field constants for the capture/compare I/O block
// Assumes: APB, 32-bit words, one register per aligned word
// Notes:   offsets are byte addresses
`ifndef CAPCMP_REGS_VH
`define CAPCMP_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CH1_IOCTL 8'h00
`define OFS_CH2_IOCTL 8'h04
`define OFS_CH3_IOCTL_HI 8'h08
`define OFS_CH3_IOCTL_LO 8'h0C
`define OFS_CH3_MODE 8'h10
`define OFS_GREG_CH1A 8'h14
`define OFS_GREG_CH2A 8'h18
`define OFS_GREG_CH3A 8'h1C
`define OFS_GREG_CH3C 8'h20
`define OFS_IRQ_STATUS 8'h24
`define OFS_IRQ_MASK 8'h28
`define OFS_PIN_STATE 8'h2C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FLD_ROLE 3
`define FLD_LVL 2
`define FLD_ACT_HI 1
`define FLD_ACT_LO 0
`define FLD_BUF_A 4
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3
`define RST_IOCTL 4'h0
`define RST_MASK 4'h0
`define NUM_UNITS 4

`endif

// ### rtl/capcmp_io_ctrl.v
// Purpose: per-register I/O control for general registers of channels 1-3
// Assumes: counter values and match strobes come from the timer core
// Notes:   units 0..3 are ch1 A, ch2 A, ch3 A, ch3 C
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "capcmp_regs.vh"

module capcmp_io_ctrl #(
  parameter CW = 16
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // timer core
  input wire [CW-1:0] ch1Count,
  input wire [CW-1:0] ch2Count,
  input wire [CW-1:0] ch3Count,
  input wire [3:0] compareHit,
  input wire ch0GregAEvent,
  input wire ch4CountStep,
  // pins, unit order ch1 A, ch2 A, ch3 A, ch3 C
  input wire [3:0] pinIn,
  output reg [3:0] pinOut,
  output reg [3:0] pinOe_b,
  // capture strobes and interrupt
  output reg [3:0] captureEvent,
  output wire irq
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // pin-source edge select per capture action
  function edgeHit;
    input [1:0] act;
    input rise;
    input fall;
    begin
      if (act[1]) begin
        edgeHit = rise | fall;
      end else if (act[0]) begin
        edgeHit = fall;
      end else begin
        edgeHit = rise;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0] ioCtl [0:3];
  reg bufferModeA;
  wire [CW-1:0] greg [0:3];
  reg [3:0] irqStatus;
  reg [3:0] irqMask;
  reg [3:0] pinPrev;
  // per-unit flop outputs, gathered so each port has one driver
  wire [3:0] unitOut;
  wire [3:0] unitOe_b;
  wire [3:0] unitCap;

  wire apbWrite = psel & penable & pwrite;
  wire apbRead = psel & penable & ~pwrite;
  wire [CW-1:0] unitCount [0:3];
  wire [3:0] unitOff;
  wire [3:0] capHit;
  wire [3:0] cmpHit;
  wire [3:0] rise = pinIn & ~pinPrev;
  wire [3:0] fall = ~pinIn & pinPrev;
  reg addrOk;

  assign unitCount[0] = ch1Count;
  assign unitCount[1] = ch2Count;
  assign unitCount[2] = ch3Count;
  assign unitCount[3] = ch3Count;
  assign unitOff = {bufferModeA, 3'h0};

  // zero-wait slave
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrOk;
  assign irq = |(irqStatus & irqMask);

  // outputs are plain copies of the per-unit flops
  always @* begin
    pinOut = unitOut;
    pinOe_b = unitOe_b;
    captureEvent = unitCap;
  end

  // ----------------------------------------------------------------
  // capture source selection per unit
  // ----------------------------------------------------------------
  // cascade from channel 0 A
  assign capHit[0] = ioCtl[0][`FLD_LVL] ? ch0GregAEvent :
    edgeHit(ioCtl[0][1:0], rise[0], fall[0]);
  assign capHit[1] = edgeHit(ioCtl[1][1:0], rise[1], fall[1]);

  genvar g;
  generate
    for (g = 2; g < 4; g = g + 1) begin : gCh3
      assign capHit[g] = ioCtl[g][`FLD_LVL] ? ch4CountStep :
        edgeHit(ioCtl[g][1:0], rise[g], fall[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // per-unit pin, capture and compare logic
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : gUnit
      wire isCap = ioCtl[g][`FLD_ROLE];
      wire [1:0] act = ioCtl[g][1:0];
      reg outQ;
      reg oeQ;
      reg capQ;
      reg [CW-1:0] gregQ;
      reg [3:0] fieldSeen;
      assign cmpHit[g] = ~unitOff[g] & ~isCap & compareHit[g];
      assign unitOut[g] = outQ;
      assign unitOe_b[g] = oeQ;
      assign unitCap[g] = capQ;
      assign greg[g] = gregQ;
      always @(posedge clock) begin
        if (!rst_b) begin
          outQ <= 1'b0;
          oeQ <= 1'b1;
          capQ <= 1'b0;
          gregQ <= {CW{1'b0}};
          fieldSeen <= `RST_IOCTL;
        end else begin
          fieldSeen <= ioCtl[g];
          capQ <= ~unitOff[g] & isCap & capHit[g];
          if (unitOff[g] || isCap || act == 2'h0) begin
            oeQ <= 1'b1;
          end else begin
            oeQ <= 1'b0;
          end
          if (ioCtl[g] != fieldSeen) begin
            outQ <= ioCtl[g][`FLD_LVL];
          end else if (cmpHit[g]) begin
            case (act)
              `ACT_LOW: begin
                outQ <= 1'b0;
              end
              `ACT_HIGH: begin
                outQ <= 1'b1;
              end
              `ACT_TOGGLE: begin
                outQ <= ~outQ;
              end
              default: begin
                outQ <= outQ;
              end
            endcase
          end
          if (apbWrite && paddr == `OFS_GREG_CH1A + 8'h04 * g) begin
            gregQ <= pwdata[CW-1:0];
          end else if (~unitOff[g] && isCap && capHit[g]) begin
            gregQ <= unitCount[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers and sticky status
  // ----------------------------------------------------------------
  // set wins over read-clear so no event is lost
  always @(posedge clock) begin
    if (!rst_b) begin
      ioCtl[0] <= `RST_IOCTL;
      ioCtl[1] <= `RST_IOCTL;
      ioCtl[2] <= `RST_IOCTL;
      ioCtl[3] <= `RST_IOCTL;
      bufferModeA <= 1'b0;
      irqStatus <= 4'h0;
      irqMask <= `RST_MASK;
      pinPrev <= 4'h0;
    end else begin
      pinPrev <= pinIn;
      if (apbWrite) begin
        case (paddr)
          `OFS_CH1_IOCTL: begin
            ioCtl[0] <= pwdata[3:0];
          end
          `OFS_CH2_IOCTL: begin
            ioCtl[1] <= pwdata[3:0];
          end
          `OFS_CH3_IOCTL_HI: begin
            ioCtl[2] <= pwdata[3:0];
          end
          `OFS_CH3_IOCTL_LO: begin
            ioCtl[3] <= pwdata[3:0];
          end
          `OFS_CH3_MODE: begin
            bufferModeA <= pwdata[`FLD_BUF_A];
          end
          `OFS_IRQ_MASK: begin
            irqMask <= pwdata[3:0];
          end
          default: begin
            bufferModeA <= bufferModeA;
          end
        endcase
      end
      if (apbRead && paddr == `OFS_IRQ_STATUS) begin
        irqStatus <= captureEvent | cmpHit;
      end else begin
        irqStatus <= irqStatus | captureEvent | cmpHit;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @* begin
    addrOk = 1'b1;
    prdata = 32'h0;
    case (paddr)
      `OFS_CH1_IOCTL: begin
        prdata[3:0] = ioCtl[0];
      end
      `OFS_CH2_IOCTL: begin
        prdata[3:0] = ioCtl[1];
      end
      `OFS_CH3_IOCTL_HI: begin
        prdata[3:0] = ioCtl[2];
      end
      `OFS_CH3_IOCTL_LO: begin
        prdata[3:0] = ioCtl[3];
      end
      `OFS_CH3_MODE: begin
        prdata[`FLD_BUF_A] = bufferModeA;
      end
      `OFS_GREG_CH1A: begin
        prdata[CW-1:0] = greg[0];
      end
      `OFS_GREG_CH2A: begin
        prdata[CW-1:0] = greg[1];
      end
      `OFS_GREG_CH3A: begin
        prdata[CW-1:0] = greg[2];
      end
      `OFS_GREG_CH3C: begin
        prdata[CW-1:0] = greg[3];
      end
      `OFS_IRQ_STATUS: begin
        prdata[3:0] = irqStatus;
      end
      `OFS_IRQ_MASK: begin
        prdata[3:0] = irqMask;
      end
      `OFS_PIN_STATE: begin
        prdata[3:0] = pinIn;
        prdata[7:4] = pinOut;
      end
      default: begin
        addrOk = 1'b0;
      end
    endcase
  end

endmodule

// ### dv/pin_side.sv
// Purpose: far-side pin model
// Assumes: bench sets the external level
// Notes:   a released pin shows the outside level
`timescale 1ns/100ps
module pin_side (
  // pin wires
  input wire [3:0] pinOut,
  input wire [3:0] pinOe_b,
  input wire [3:0] ext,
  output wire [3:0] pinIn
);
  assign pinIn = (~pinOe_b & pinOut) | (pinOe_b & ext);
endmodule

// ### dv/capcmp_io_ctrl_asserts.sv
// Purpose: port checks for unit 0
// Assumes: unit 0 field shadowed from APB writes
// Notes:   bound to the design below
`timescale 1ns/100ps
module capcmp_io_ctrl_asserts (
  // watched ports
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] compareHit,
  input wire ch0GregAEvent,
  input wire [3:0] pinIn,
  input wire [3:0] pinOut,
  input wire [3:0] pinOe_b,
  input wire [3:0] captureEvent
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  reg [3:0] f;
  reg p;
  wire w0 = psel && penable && pwrite && paddr == 8'h00;
  // field shadow and previous pin level
  always @(posedge clock) begin
    p <= pinIn[0];
    f <= !rst_b ? 4'h0 : w0 ? pwdata[3:0] : f;
  end
  property p_off;
    w0 && pwdata[1:0] == 2'h0 |-> ##2 pinOe_b[0];
  endproperty
  a_off: assert property (p_off) else $error("pin driven");
  property p_lvl;
    w0 && !pwdata[3] && pwdata[3:0] != f ##1 !compareHit[0]
      |=> pinOut[0] == $past(pwdata[2], 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("bad level");
  property p_lo;
    !f[3] && f[1:0] == 2'h1 && compareHit[0] && $stable(f) |=> !pinOut[0];
  endproperty
  a_lo: assert property (p_lo) else $error("not low");
  property p_hi;
    !f[3] && f[1:0] == 2'h2 && compareHit[0] && $stable(f) |=> pinOut[0];
  endproperty
  a_hi: assert property (p_hi) else $error("not high");
  property p_tg;
    !f[3] && f[1:0] == 2'h3 && compareHit[0] && $stable(f)
      |=> pinOut[0] != $past(pinOut[0]);
  endproperty
  a_tg: assert property (p_tg) else $error("no toggle");
  property p_ri;
    f == 4'h8 && pinIn[0] && !p |=> captureEvent[0];
  endproperty
  a_ri: assert property (p_ri) else $error("rise lost");
  property p_fa;
    f == 4'h9 && !pinIn[0] && p |=> captureEvent[0];
  endproperty
  a_fa: assert property (p_fa) else $error("fall lost");
  property p_cas;
    f[3:2] == 2'h3 && ch0GregAEvent |=> captureEvent[0];
  endproperty
  a_cas: assert property (p_cas) else $error("chain lost");
endmodule
bind capcmp_io_ctrl capcmp_io_ctrl_asserts chk_i (.clock, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .compareHit, .ch0GregAEvent, .pinIn,
  .pinOut, .pinOe_b, .captureEvent);

// ### dv/timer_ch1_3_io_capture_compare_ctrl_bench.sv
// Purpose: self-checking bench
// Assumes: zero-wait APB, read results queued
// Notes:   all counts share one random value
`timescale 1ns/100ps
module timer_ch1_3_io_capture_compare_ctrl_bench;
  reg clock, rst_b, psel, penable, pwrite, ch0GregAEvent, ch4CountStep, o;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [15:0] cnt;
  reg [15:0] r [0:2];
  reg [3:0] compareHit, ext, c;
  reg [31:0] q [$];
  wire pready, pslverr, irq;
  wire [31:0] prdata;
  wire [3:0] pinIn, pinOut, pinOe_b, captureEvent;
  integer fails = 0, check_count = 0, cyc = 0, u, k, i;
  capcmp_io_ctrl dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch1Count(cnt),
    .ch2Count(cnt), .ch3Count(cnt), .compareHit(compareHit),
    .ch0GregAEvent(ch0GregAEvent), .ch4CountStep(ch4CountStep),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_b(pinOe_b),
    .captureEvent(captureEvent), .irq(irq));
  pin_side pins (.pinOut(pinOut), .pinOe_b(pinOe_b), .ext(ext), .pinIn(pinIn));
  task chk(input [31:0] s, input [31:0] e, input string n);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // request held until pready seen at a rising edge
  task apb(input [7:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  // one-cycle event pulses, then let status settle
  task step(input [1:0] m);
    ch0GregAEvent <= m[0];
    ch4CountStep <= m[1];
    @(posedge clock);
    ch0GregAEvent <= 1'b0;
    ch4CountStep <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // read data taken at the access edge against the oldest note
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (psel && penable && !pwrite && pready)
      chk(prdata, q.pop_front(), "prdata");
    if (cyc > 4000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, ch0GregAEvent, ch4CountStep} = 6'h00;
    {paddr, pwdata, cnt, compareHit, ext} = 64'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    k = $urandom(95205);
    for (k = 0; k < 4; k++) rd({k[5:0], 2'h0}, 32'h0);
    apb(8'h30, 1'b1, 32'hF);
    rd(8'h30, 32'h0);
    for (k = 1; k < 9; k++) begin
      c = {1'b0, k[2:0]};
      apb(8'h00, 1'b1, {28'h0, c});
      compareHit[0] <= 1'b1;
      @(posedge clock);
      compareHit[0] <= 1'b0;
      @(posedge clock);
      o = c[1:0] == 2'h0 ? c[2] : c[1:0] == 2'h3 ? !c[2] : c[1];
      rd(8'h2C, {27'h0, o, 3'h0, o & |c[1:0]});
    end
    for (u = 0; u < 4; u++)
      for (k = 0; k < 4; k++) begin
        c = k == 3 ? 4'hC : 4'h8 + k[3:0];
        apb({u[5:0], 2'h0}, 1'b1, {28'h0, c});
        for (i = 0; i < 3; i++) begin
          r[i] = 16'($urandom);
          cnt <= r[i];
          ext[u] <= i == 0;
          step({2{i == 2}});
        end
        rd(8'h14 + {u[5:0], 2'h0}, {16'h0, (k == 3 && u != 1) ? r[2] :
          (k == 0 || k == 3) ? r[0] : r[1]});
      end
    for (k = 0; k < 4; k++) rd({k[5:0], 2'h0}, 32'hC);
    // status sticky, read clears, mask gates irq
    rd(8'h24, 32'hF);
    rd(8'h24, 32'h0);
    apb(8'h28, 1'b1, 32'h1);
    step(2'b10);
    chk(irq, 32'h0, "irq");
    step(2'b01);
    chk(irq, 32'h1, "irq");
    rd(8'h24, 32'hD);
    chk(irq, 32'h0, "irq");
    apb(8'h10, 1'b1, 32'h10);
    cnt <= r[0];
    step(2'b10);
    rd(8'h20, {16'h0, r[2]});
    rd(8'h24, 32'h4);
    complete_run;
  end
endmodule
